// ### rtl/sadc_top.sv
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_top #(
  parameter int BITS = `SADC_BITS,
  parameter int ACQ_CYC = `SADC_ACQ_CYC,
  parameter int CONV_CYC = `SADC_CONV_CYC,
  parameter int SCLK_HALF = `SADC_SCLK_HALF
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk_ext_i,
  input wire logic reset_pin_i,
  input wire logic power_down_request_i,
  input wire logic convert_start_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic serial_port_select_i,
  input wire logic clock_source_select_i,
  input wire logic clock_edge_invert_i,
  input wire logic frame_polarity_invert_i,
  input wire logic read_mode_or_chain_in_i,
  input wire logic code_format_select_i,
  input wire logic [BITS-1:0] sar_code_i,
  output logic [BITS-1:0] data_o,
  output logic [BITS-1:0] data_oe_o,
  output logic busy_o
);
  localparam logic [15:0] ACQ_LAST = 16'(ACQ_CYC - 1);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [4:0] BIT_LAST = 5'(BITS - 1);

  logic [`SADC_SYNC_W-1:0] raw;
  logic [`SADC_SYNC_W-1:0] s;
  logic link_clk;
  logic link_sdo;
  logic link_mid;
  logic read_en;
  logic ser;
  logic ext;

  sadc_pkg::sadc_state_t state_r;
  sadc_pkg::sadc_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [BITS-1:0] result_r;
  logic [BITS-1:0] result_nxt;
  logic done_r;
  logic done_nxt;
  logic cnv_prev_r;

  logic frame_r;
  logic frame_nxt;
  logic ph_r;
  logic ph_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [4:0] bcnt_r;
  logic [4:0] bcnt_nxt;
  logic [BITS-1:0] sh_r;
  logic [BITS-1:0] sh_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic sent_r;
  logic sent_nxt;
  logic err_r;
  logic err_nxt;

  logic [BITS-1:0] pin_r;
  logic [BITS-1:0] pin_nxt;
  logic [BITS-1:0] oe_r;
  logic [BITS-1:0] oe_nxt;
  logic ser_ext_r;

  always_comb
  begin
    raw = '0;
    raw[`SADC_SI_CS] = cs_n_i;
    raw[`SADC_SI_RD] = rd_n_i;
    raw[`SADC_SI_CNV] = convert_start_n_i;
    raw[`SADC_SI_PD] = power_down_request_i;
    raw[`SADC_SI_RST] = reset_pin_i;
    raw[`SADC_SI_RDC] = read_mode_or_chain_in_i;
    raw[`SADC_SI_MID] = link_mid;
    raw[`SADC_SI_SER] = serial_port_select_i;
    raw[`SADC_SI_EXT] = clock_source_select_i;
    raw[`SADC_SI_FMT] = code_format_select_i;
    raw[`SADC_SI_INVC] = clock_edge_invert_i;
    raw[`SADC_SI_INVS] = frame_polarity_invert_i;
  end

  sadc_sync #(
    .W(`SADC_SYNC_W)
  ) u_sync (
    .clk_i(mclk_i),
    .d_i(raw),
    .q_o(s)
  );

  assign read_en = !s[`SADC_SI_CS] && !s[`SADC_SI_RD];
  assign ser = s[`SADC_SI_SER];
  assign ext = s[`SADC_SI_EXT];

  // Inversion moves the update edge onto the falling edge of the external serial clock
  assign link_clk = sclk_ext_i ^ clock_edge_invert_i;

  sadc_link #(
    .BITS(BITS)
  ) u_link (
    .link_clk_i(link_clk),
    .cs_n_i(cs_n_i),
    .word_i(result_r),
    .chain_i(read_mode_or_chain_in_i),
    .serial_o(link_sdo),
    .mid_read_o(link_mid)
  );

  // Conversion sequencing
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    result_nxt = result_r;
    done_nxt = 1'b0;
    case (state_r)
      sadc_pkg::SADC_ACQ:
      begin
        if (cnt_r != ACQ_LAST)
        begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        else if (!s[`SADC_SI_PD])
        begin
          cnt_nxt = '0;
          if (!s[`SADC_SI_CNV])
          begin
            state_nxt = sadc_pkg::SADC_CONV;
            busy_nxt = 1'b1;
          end
          else
          begin
            state_nxt = sadc_pkg::SADC_WAIT;
          end
        end
      end
      sadc_pkg::SADC_WAIT:
      begin
        if (cnv_prev_r && !s[`SADC_SI_CNV] && !s[`SADC_SI_PD])
        begin
          state_nxt = sadc_pkg::SADC_CONV;
          busy_nxt = 1'b1;
        end
      end
      sadc_pkg::SADC_CONV:
      begin
        if (cnt_r != CONV_LAST)
        begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        else
        begin
          // Raw code is straight binary; twos complement flips the sign bit
          result_nxt = sar_code_i ^ {!s[`SADC_SI_FMT], {(BITS-1){1'b0}}};
          state_nxt = sadc_pkg::SADC_ACQ;
          cnt_nxt = '0;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      default:
      begin
        state_nxt = sadc_pkg::SADC_ACQ;
      end
    endcase
    if (s[`SADC_SI_RST])
    begin
      state_nxt = sadc_pkg::SADC_ACQ;
      cnt_nxt = '0;
      busy_nxt = 1'b0;
      result_nxt = '0;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= sadc_pkg::SADC_ACQ;
      cnt_r <= '0;
      busy_r <= 1'b0;
      result_r <= '0;
      done_r <= 1'b0;
      cnv_prev_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      result_r <= result_nxt;
      done_r <= done_nxt;
      cnv_prev_r <= s[`SADC_SI_CNV];
    end
  end

  // Internal serial clock, frame and shifter; one frame per result
  always_comb
  begin
    frame_nxt = frame_r;
    ph_nxt = ph_r;
    div_nxt = div_r;
    bcnt_nxt = bcnt_r;
    sh_nxt = sh_r;
    sdo_nxt = sdo_r;
    sent_nxt = done_r ? 1'b0 : sent_r;
    err_nxt = done_r && ser && ext && s[`SADC_SI_MID];
    if (!frame_r)
    begin
      if (ser && !ext && read_en && !sent_r && (s[`SADC_SI_RDC] || !busy_r))
      begin
        frame_nxt = 1'b1;
        sent_nxt = 1'b1;
        sh_nxt = result_r;
        sdo_nxt = result_r[BITS-1];
        ph_nxt = 1'b0;
        div_nxt = '0;
        bcnt_nxt = '0;
      end
    end
    else if (!read_en)
    begin
      frame_nxt = 1'b0;
      ph_nxt = 1'b0;
    end
    else if (div_r != HALF_LAST)
    begin
      div_nxt = div_r + 8'h01;
    end
    else
    begin
      div_nxt = '0;
      ph_nxt = !ph_r;
      if (ph_r)
      begin
        sh_nxt = {sh_r[BITS-2:0], 1'b0};
        sdo_nxt = sh_r[BITS-2];
        bcnt_nxt = bcnt_r + 5'h01;
        if (bcnt_r == BIT_LAST)
        begin
          frame_nxt = 1'b0;
        end
      end
    end
    if (s[`SADC_SI_RST])
    begin
      frame_nxt = 1'b0;
      ph_nxt = 1'b0;
      sent_nxt = 1'b0;
      err_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      frame_r <= 1'b0;
      ph_r <= 1'b0;
      div_r <= '0;
      bcnt_r <= '0;
      sh_r <= '0;
      sdo_r <= 1'b0;
      sent_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      frame_r <= frame_nxt;
      ph_r <= ph_nxt;
      div_r <= div_nxt;
      bcnt_r <= bcnt_nxt;
      sh_r <= sh_nxt;
      sdo_r <= sdo_nxt;
      sent_r <= sent_nxt;
      err_r <= err_nxt;
    end
  end

  // Pin functions and drivers
  always_comb
  begin
    pin_nxt = result_r;
    oe_nxt = '0;
    if (!ser)
    begin
      oe_nxt = read_en ? '1 : '0;
    end
    else
    begin
      pin_nxt[`SADC_PIN_SDO] = sdo_r;
      oe_nxt[`SADC_PIN_SDO] = read_en;
      pin_nxt[`SADC_PIN_SCLK] = ph_r ^ s[`SADC_SI_INVC];
      oe_nxt[`SADC_PIN_SCLK] = !ext;
      pin_nxt[`SADC_PIN_SYNC] = frame_r ^ s[`SADC_SI_INVS];
      oe_nxt[`SADC_PIN_SYNC] = !ext;
      pin_nxt[`SADC_PIN_ERR] = err_r;
      oe_nxt[`SADC_PIN_ERR] = ext;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pin_r <= '0;
      oe_r <= '0;
      ser_ext_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      ser_ext_r <= ser && ext;
    end
  end

  // External-clock data leaves the link flop directly; a core flop would add mclk skew
  assign data_o = {pin_r[BITS-1:`SADC_PIN_SDO+1], ser_ext_r ? link_sdo : pin_r[`SADC_PIN_SDO],
                   pin_r[`SADC_PIN_SDO-1:0]};
  assign data_oe_o = oe_r;
  assign busy_o = busy_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i || s[`SADC_SI_RST]);

  sequence s_acq_end;
    state_r == sadc_pkg::SADC_ACQ && cnt_r == ACQ_LAST;
  endsequence

  sequence s_cnv_fall;
    state_r == sadc_pkg::SADC_WAIT && cnv_prev_r && !s[`SADC_SI_CNV];
  endsequence

  sequence s_frame_start;
    $rose(frame_r);
  endsequence

  property p_busy_rise;
    s_acq_end ##0 (!s[`SADC_SI_PD] && !s[`SADC_SI_CNV]) |=> busy_r && state_r == sadc_pkg::SADC_CONV;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised at start");

  property p_edge_start;
    s_cnv_fall ##0 !s[`SADC_SI_PD] |=> busy_r ##1 busy_r;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("no start on falling edge");

  property p_busy_fall;
    $fell(busy_r) |-> $past(state_r) == sadc_pkg::SADC_CONV && $past(cnt_r) == CONV_LAST && done_r;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell early");

  property p_busy_start;
    $rose(busy_r) |-> cnt_r == 16'h0000 ##1 busy_r;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not held from start");

  property p_pd_block;
    s_acq_end ##0 s[`SADC_SI_PD] |=> !busy_r && state_r == sadc_pkg::SADC_ACQ;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("start under power-down");

  property p_msb_hiz;
    $past(ser) |-> data_oe_o[BITS-1:`SADC_PIN_ERR+1] == '0;
  endproperty
  a_msb_hiz: assert property (p_msb_hiz) else $error("upper pins driven in serial");

  property p_par_gate;
    !$past(ser) |-> data_oe_o == ($past(read_en) ? '1 : '0);
  endproperty
  a_par_gate: assert property (p_par_gate) else $error("parallel drive wrong");

  property p_frame_hold;
    s_frame_start ##0 read_en[*4] |-> frame_r && sdo_r == sh_r[BITS-1];
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame dropped early");

  property p_rdc_mode;
    s_frame_start ##0 $past(busy_r) |-> $past(s[`SADC_SI_RDC]);
  endproperty
  a_rdc_mode: assert property (p_rdc_mode) else $error("read during conversion");

  property p_err_pulse;
    done_r && ser && ext && s[`SADC_SI_MID] ##1 !s[`SADC_SI_RST] |=> data_o[`SADC_PIN_ERR] ##1 !data_o[`SADC_PIN_ERR];
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("read error flag not pulsed");
endmodule : sadc_top

// ### rtl/sadc_params.svh
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
// Notes on behaviour
// - Serial mode: clock pin drives out with internal source, is input with external.
// - Clock-invert input picks which serial clock edge updates serial data.
// - Frame sync goes active at read start, held while data valid; polarity by invert.
// - Frame sync only driven in serial mode with internal clock source.
// - External clocking: read unfinished at next conversion end pulses incomplete-read flag.
// - Parallel mode: full 16-bit result on data pins, serial pins become bits 8-11.
// - Serial mode: top four parallel data pins stay high impedance.
// - Busy rises as soon as a conversion begins.
// - Busy stays high until result is loaded; its fall marks data ready.
// - Data drivers enabled only while chip select and read are both low; serial clock, sync and error pins are not gated by them.
// - Chip select gates the external serial clock; edges ignored while deselected.
// - Reset input high resets logic and aborts any running conversion.
// - Power-down lets current conversion finish, then refuses new starts.
// - Start input high at acquisition end: convert on its next falling edge.
// - Start input already low at acquisition end: convert immediately.
// - Result shifted out most significant bit first, in the selected coding.
// - External clock: update on rising edge, or falling when inverted.
// - Internal clock: read-mode high reads previous result during conversion, else after.
// - External clock: chain input reaches serial output 16 clock periods after start.
`define SADC_BITS 16
`define SADC_MCLK_MHZ 50
`define SADC_ACQ_NS 1000
`define SADC_ACQ_CYC ((`SADC_ACQ_NS * `SADC_MCLK_MHZ + 999) / 1000)
`define SADC_CONV_NS 3000
`define SADC_CONV_CYC ((`SADC_CONV_NS * `SADC_MCLK_MHZ) / 1000)
`define SADC_SCLK_HALF 2
`define SADC_PIN_SDO 8
`define SADC_PIN_SCLK 9
`define SADC_PIN_SYNC 10
`define SADC_PIN_ERR 11
`define SADC_SI_CS 0
`define SADC_SI_RD 1
`define SADC_SI_CNV 2
`define SADC_SI_PD 3
`define SADC_SI_RST 4
`define SADC_SI_RDC 5
`define SADC_SI_MID 6
`define SADC_SI_SER 7
`define SADC_SI_EXT 8
`define SADC_SI_FMT 9
`define SADC_SI_INVC 10
`define SADC_SI_INVS 11
`define SADC_SYNC_W 12
`endif

// ### rtl/sadc_pkg.sv
package sadc_pkg;
  typedef enum logic [1:0] {SADC_ACQ, SADC_WAIT, SADC_CONV} sadc_state_t;
endpackage : sadc_pkg

// ### rtl/sadc_sync.sv
`timescale 1ns/1ps
module sadc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i)
  begin
    meta_r <= d_i;
    q_r <= meta_r;
  end

  assign q_o = q_r;
endmodule : sadc_sync

// ### rtl/sadc_link.sv
`timescale 1ns/1ps
module sadc_link #(
  parameter int BITS = 16
) (
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic [BITS-1:0] word_i,
  input wire logic chain_i,
  output logic serial_o,
  output logic mid_read_o
);
  localparam int CW = $clog2(BITS) + 1;
  localparam logic [CW-1:0] LAST = CW'(BITS);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [BITS-1:0] sh_r;
  logic [BITS-1:0] sh_nxt;
  logic out_r;
  logic out_nxt;
  logic mid_r;
  logic mid_nxt;

  // Word is held still by the core while busy is low, so no crossing beyond that
  always_comb
  begin
    cnt_nxt = cnt_r;
    sh_nxt = {sh_r[BITS-2:0], chain_i};
    out_nxt = sh_r[BITS-1];
    if (cnt_r == '0)
    begin
      sh_nxt = {word_i[BITS-2:0], chain_i};
      out_nxt = word_i[BITS-1];
    end
    if (cnt_r != LAST)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    mid_nxt = (cnt_nxt != '0) && (cnt_nxt != LAST);
  end

  // Deselect clears the frame, so edges while deselected are lost
  always_ff @(posedge link_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      cnt_r <= '0;
      sh_r <= '0;
      out_r <= 1'b0;
      mid_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      mid_r <= mid_nxt;
    end
  end

  assign serial_o = out_r;
  assign mid_read_o = mid_r;
endmodule : sadc_link

// ### verification/sadc_host.sv
`timescale 1ns/1ps
module sadc_host (
  input wire logic data_i,
  output logic sclk_o,
  output logic chain_o,
  output logic [31:0] word_o
);
  initial
  begin
    sclk_o = 1'b0;
    chain_o = 1'b1;
    word_o = 32'h0000_0000;
  end
  // Clock stands low between frames, 32 ns period inside them
  // Chain input alternates from 1 so the tail order shows up in the word
  task automatic burst(input int n);
    word_o = 32'h0000_0000;
    chain_o = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      #16 sclk_o = 1'b1;
      // Sample on the edge opposite the update edge
      #16 sclk_o = 1'b0;
      word_o = {word_o[30:0], data_i};
      chain_o = !chain_o;
    end
  endtask : burst
endmodule : sadc_host

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int CONV = 8;
  typedef struct packed {logic [15:0] code; logic fmt; logic [15:0] exp;} sadc_row_t;
  localparam sadc_row_t ROWS [5] = '{
    '{16'h1234, 1'b1, 16'h1234}, '{16'h1234, 1'b0, 16'h9234}, '{16'hFFFF, 1'b0, 16'h7FFF},
    '{16'h8000, 1'b1, 16'h8000}, '{16'h0000, 1'b0, 16'h8000}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reset_pin = 1'b0;
  logic pd = 1'b0;
  logic cnv_n = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic ser = 1'b0;
  logic ext = 1'b0;
  logic invs = 1'b0;
  logic fmt = 1'b1;
  logic invc = 1'b0;
  logic rdm = 1'b0;
  logic [15:0] code = 16'h0000;
  logic [15:0] data;
  logic [15:0] oe;
  logic busy;
  logic sclk;
  logic chain;
  logic [31:0] hword;
  logic rdc;
  int failures = 0;
  int comparisons = 0;
  assign rdc = ext ? chain : rdm;
  always #10 clk = ~clk;
  sadc_top #(.ACQ_CYC(4), .CONV_CYC(CONV), .SCLK_HALF(1)) i_dut (
    .mclk_i(clk), .rst_b_i(rst_b), .sclk_ext_i(sclk), .reset_pin_i(reset_pin),
    .power_down_request_i(pd), .convert_start_n_i(cnv_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .serial_port_select_i(ser), .clock_source_select_i(ext), .clock_edge_invert_i(invc),
    .frame_polarity_invert_i(invs), .read_mode_or_chain_in_i(rdc), .code_format_select_i(fmt),
    .sar_code_i(code), .data_o(data), .data_oe_o(oe), .busy_o(busy));
  sadc_host i_host (.data_i(data[8]), .sclk_o(sclk), .chain_o(chain), .word_o(hword));
  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic watch(input int cyc, input int pin, output logic seen);
    seen = 1'b0;
    repeat (cyc)
    begin
      @(negedge clk);
      seen = seen | (pin < 0 ? busy : data[pin]);
    end
  endtask : watch
  task automatic convert();
    int n;
    cnv_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("busy_rise", n < 200, 1);
    cnv_n = 1'b1;
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("busy_len", n, CONV);
  endtask : convert
  task automatic pread(input logic [15:0] exp);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    check("par_oe", oe, 16'hFFFF);
    check("par_data", data, exp);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    check("par_oe_off", oe, 16'h0000);
    rd_n = 1'b1;
  endtask : pread
  initial
  begin
    int n;
    int k;
    logic p;
    logic bad;
    logic seen;
    logic [15:0] w;
    repeat (8) @(negedge clk);
    check("rst_busy", busy, 0);
    check("rst_oe", oe, 0);
    rst_b = 1'b1;
    foreach (ROWS[i])
    begin
      code = ROWS[i].code;
      fmt = ROWS[i].fmt;
      convert();
      pread(ROWS[i].exp);
    end
    // Power-down blocks starts; after release a fresh falling edge is needed
    pd = 1'b1;
    cnv_n = 1'b0;
    watch(40, -1, seen);
    check("pd_block", seen, 0);
    cnv_n = 1'b1;
    pd = 1'b0;
    repeat (4) @(negedge clk);
    convert();
    watch(30, -1, seen);
    check("wait_edge", seen, 0);
    convert();
    // Reset pin mid-conversion
    code = 16'hABCD;
    fmt = 1'b1;
    cnv_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    reset_pin = 1'b1;
    cnv_n = 1'b1;
    repeat (5) @(negedge clk);
    check("abort_busy", busy, 0);
    reset_pin = 1'b0;
    repeat (4) @(negedge clk);
    pread(16'h0000);
    // Serial, internal clock, both frame polarities
    ser = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      invs = s[0];
      invc = s[0];
      code = 16'hA5C3;
      convert();
      cs_n = 1'b0;
      rd_n = 1'b0;
      w = 16'h0000;
      k = 0;
      n = 0;
      bad = 1'b0;
      p = data[9];
      while (k < 16 && n < 300)
      begin
        @(negedge clk);
        n++;
        if ((data[9] ^ invc) === 1'b1 && (p ^ invc) === 1'b0)
        begin
          w = {w[14:0], data[8]};
          k++;
          bad = bad | (data[10] !== ~invs);
        end
        p = data[9];
      end
      check("int_word", w, 16'hA5C3);
      check("int_sync", bad, 0);
      check("int_oe_hi", oe[15:12], 0);
      check("int_sclk_oe", oe[9], 1);
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (4) @(negedge clk);
    end
    // Read mode high: the previous result goes out during conversion
    invs = 1'b0;
    invc = 1'b0;
    rdm = 1'b1;
    convert();
    cnv_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    cnv_n = 1'b1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    watch(5, 10, seen);
    check("rdc_frame", {seen, busy}, 2'b11);
    cs_n = 1'b1;
    rd_n = 1'b1;
    rdm = 1'b0;
    repeat (10) @(negedge clk);
    // Serial, external clock: gated edges, full word, chain tail
    ext = 1'b1;
    code = 16'h3C5A;
    convert();
    i_host.burst(3);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    i_host.burst(18);
    @(negedge clk);
    check("ext_word", hword[17:0], {16'h3C5A, 2'b10});
    check("ext_sclk_oe", oe[9], 0);
    check("ext_sync_oe", oe[10], 0);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    // Partial read overtaken by the next conversion
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    i_host.burst(5);
    @(negedge clk);
    convert();
    watch(10, 11, seen);
    check("rd_error", seen, 1);
    cs_n = 1'b1;
    rd_n = 1'b1;
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : testbench
